// ---- hw/opmode_pkg.sv ----
/*
 * Constants for the operating-mode and reset sequencer: mode field
 * codes, flag reset values and timing figures at the 40 MHz clock.
 * Assumes nothing of its surroundings.
 */
package opmode_pkg;

    localparam int          CLK_MHZ          = 40;
    localparam int          CLK_PERIOD_NS    = 25;

    // Low-power mode field encodings.
    localparam logic [1:0]  MODE_FIELD_RUN   = 2'h0;
    localparam logic [1:0]  MODE_FIELD_HALT  = 2'h1;
    localparam logic [1:0]  MODE_FIELD_STBY  = 2'h2;

    // Oscillator control register bit positions.
    localparam int          OSC_SEL_BIT      = 0;
    localparam int          OSC_STOP_BIT     = 1;
    localparam int          OSC_MODE_LSB     = 2;

    // Values after reset.
    localparam logic        SEL_FAST_RST     = 1'b1;
    localparam logic        FAST_STOP_RST    = 1'b0;
    localparam logic        FLAG_RST         = 1'b1;

    // Wake-up stable counts in system clock cycles.
    localparam int          WAKE_XTAL_CYC    = 512;
    localparam int          WAKE_RC_CYC      = 16;
    localparam int          OST_CYC          = 16;

    // Power-up reset times in microseconds, tenths for the 4.5 ms entry.
    localparam int          PWRUP_0_US       = 140;
    localparam int          PWRUP_1_US10     = 45000;
    localparam int          PWRUP_2_US       = 18000;
    localparam int          PWRUP_3_US       = 72000;
    localparam int          PWRUP_4_US       = 288000;

    localparam int          PWRUP_0_CYC      = PWRUP_0_US * CLK_MHZ;
    localparam int          PWRUP_1_CYC      = PWRUP_1_US10 * CLK_MHZ / 10;
    localparam int          PWRUP_2_CYC      = PWRUP_2_US * CLK_MHZ;
    localparam int          PWRUP_3_CYC      = PWRUP_3_US * CLK_MHZ;
    localparam int          PWRUP_4_CYC      = PWRUP_4_US * CLK_MHZ;

    localparam vector       = 0;
    localparam logic [11:0] INT_VECTOR_ADDR  = 12'h008;

    typedef enum logic [2:0] {
        ST_RESET, ST_PWRUP, ST_OST, ST_RUN, ST_STBY, ST_HALT, ST_WAKE
    } seq_state_t;

endpackage : opmode_pkg

// ---- hw/wait_counter.sv ----
/*
 * Loadable down counter that flags when a wait has run out.
 * Assumes a load pulse from the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module wait_counter #(
    parameter int WIDTH = 24
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    // Control
    input  wire logic             i_load,
    input  wire logic [WIDTH-1:0] i_count,
    // Status
    output logic                  o_done
);
    logic [WIDTH-1:0] cnt_r;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cnt_r <= '0;
        end else if (i_load) begin
            cnt_r <= i_count;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_done <= 1'b0;
        end else begin
            o_done <= !i_load && (cnt_r == {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end
endmodule : wait_counter
`default_nettype wire

// ---- hw/opmode_reset_ctrl.sv ----
/*
 * Operating-mode and reset sequencer: collects reset events, runs the
 * power-up and oscillator start-up waits, steers clocks and the core
 * through normal, slow, standby and halt, and keeps the two status flags.
 * Assumes wake and core strobes are synchronous one-cycle pulses and the
 * external reset pin is asynchronous.
 */
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module opmode_reset_ctrl
    import opmode_pkg::*;
#(
    parameter int P0_CYC = PWRUP_0_CYC,
    parameter int P1_CYC = PWRUP_1_CYC,
    parameter int P2_CYC = PWRUP_2_CYC,
    parameter int P3_CYC = PWRUP_3_CYC,
    parameter int P4_CYC = PWRUP_4_CYC
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // Reset event sources
    input  wire logic        i_power_on_reset,
    input  wire logic        i_low_voltage_reset,
    input  wire logic        i_ext_reset_pin_n,
    input  wire logic        i_watchdog_reset,
    // Configuration options
    input  wire logic        i_startup_fast,
    input  wire logic [2:0]  i_pwrup_sel,
    input  wire logic        i_high_crystal_mode,
    input  wire logic        i_mid_crystal_mode,
    input  wire logic        i_low_crystal_mode,
    input  wire logic        i_timer0_src_opt,
    // Register port
    input  wire logic [1:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [7:0]       o_rdata,
    // Core events
    input  wire logic        i_sleep_instruction,
    input  wire logic        i_watchdog_clear_instruction,
    input  wire logic        i_global_int_en,
    input  wire logic        i_timer0_enable,
    input  wire logic        i_timer1_enable,
    input  wire logic        i_timer2_enable,
    input  wire logic        i_timer0_low_clock_sel,
    // Wake-up events
    input  wire logic        i_timer_wake,
    input  wire logic        i_watchdog_wake,
    input  wire logic        i_portb_change_wake,
    input  wire logic        i_ext_int_wake,
    // Outputs to core and clocking
    output logic             o_core_run,
    output logic             o_core_reset,
    output logic             o_sys_clk_fast,
    output logic             o_fast_osc_en,
    output logic             o_slow_osc_en,
    output logic             o_periph_en,
    output logic [2:0]       o_timer_run,
    output logic             o_timer0_slow_clk,
    output logic             o_watchdog_clear,
    output logic             o_wake_vector,
    output logic             o_time_out_flag_n,
    output logic             o_power_down_flag_n
);
    localparam logic [1:0] ADDR_OSC = 2'h0;
    localparam logic [1:0] ADDR_STS = 2'h1;
    localparam int         CW      = 24;

    seq_state_t        state_r;
    logic              pin_s1_r, pin_s2_r;
    logic              sys_clk_select_fast;
    logic              fast_osc_stop;
    logic              time_out_flag_n;
    logic              power_down_flag_n;
    logic              wait_load;
    logic [CW-1:0]     wait_count;
    logic              wait_done;
    logic              any_rst;
    logic              osc_wr;
    logic              halt_req;
    logic              stby_req;
    logic              xtal_mode;
    logic              stby_wake_hit;
    logic              halt_wake_hit;

    function automatic logic [CW-1:0] pwrup_cycles(input logic [2:0] sel);
        case (sel)
            3'h0:    pwrup_cycles = CW'(P0_CYC);
            3'h1:    pwrup_cycles = CW'(P1_CYC);
            3'h2:    pwrup_cycles = CW'(P2_CYC);
            3'h3:    pwrup_cycles = CW'(P3_CYC);
            default: pwrup_cycles = CW'(P4_CYC);
        endcase
    endfunction : pwrup_cycles

    // Wake sources that may end standby.
    function automatic logic stby_wake(input logic tmr, wdt, pbc, ext);
        stby_wake = tmr || wdt || pbc || ext;
    endfunction : stby_wake

    // Wake sources that may end halt; timers are off there.
    function automatic logic halt_wake(input logic wdt, pbc, ext);
        halt_wake = wdt || pbc || ext;
    endfunction : halt_wake

    // Pin synchroniser.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
        end else begin
            pin_s1_r <= i_ext_reset_pin_n;
            pin_s2_r <= pin_s1_r;
        end
    end

    assign any_rst   = i_power_on_reset || i_low_voltage_reset ||
                       !pin_s2_r || i_watchdog_reset;
    assign osc_wr    = i_wr && (i_addr == ADDR_OSC);
    assign halt_req  = (state_r == ST_RUN) && (i_sleep_instruction ||
        (osc_wr && i_wdata[OSC_MODE_LSB +: 2] == MODE_FIELD_HALT));
    assign stby_req  = (state_r == ST_RUN) && osc_wr &&
        (i_wdata[OSC_MODE_LSB +: 2] == MODE_FIELD_STBY);
    assign xtal_mode = i_high_crystal_mode || i_mid_crystal_mode ||
                       i_low_crystal_mode;
    assign stby_wake_hit = stby_wake(i_timer_wake, i_watchdog_wake,
                                     i_portb_change_wake, i_ext_int_wake);
    assign halt_wake_hit = halt_wake(i_watchdog_wake, i_portb_change_wake,
                                     i_ext_int_wake);

    // Sequencer state.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_r <= ST_RESET;
        end else if (any_rst) begin
            state_r <= ST_RESET;
        end else begin
            unique case (state_r)
                ST_RESET: state_r <= ST_PWRUP;
                ST_PWRUP: if (wait_done) state_r <= ST_OST;
                ST_OST:   if (wait_done) state_r <= ST_RUN;
                ST_RUN: begin
                    if (halt_req) begin
                        state_r <= ST_HALT;
                    end else if (stby_req) begin
                        state_r <= ST_STBY;
                    end
                end
                ST_STBY: begin
                    if (stby_wake_hit) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_HALT: begin
                    if (halt_wake_hit) begin
                        state_r <= ST_WAKE;
                    end
                end
                ST_WAKE:  if (wait_done) state_r <= ST_RUN;
            endcase
        end
    end

    // Wait counter loads.
    always_comb begin
        wait_load  = 1'b0;
        wait_count = '0;
        if (state_r == ST_RESET) begin
            wait_load  = 1'b1;
            wait_count = pwrup_cycles(i_pwrup_sel);
        end else if (state_r == ST_PWRUP && wait_done) begin
            wait_load  = 1'b1;
            wait_count = CW'(OST_CYC);
        end else if (state_r == ST_HALT) begin
            wait_load  = 1'b1;
            wait_count = xtal_mode ? CW'(WAKE_XTAL_CYC)
                                   : CW'(WAKE_RC_CYC);
        end
    end

    wait_counter #(
        .WIDTH   (CW)
    ) u_wait (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_load  (wait_load),
        .i_count (wait_count),
        .o_done  (wait_done)
    );

    // Clock select bit.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sys_clk_select_fast <= SEL_FAST_RST;
        end else if (state_r == ST_RESET || state_r == ST_PWRUP) begin
            sys_clk_select_fast <= i_startup_fast;
        end else if (osc_wr && state_r == ST_RUN) begin
            sys_clk_select_fast <= i_wdata[OSC_SEL_BIT];
        end
    end

    // Fast oscillator stop bit, written also by a halt or standby entry through the register, not by the sleep instruction.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            fast_osc_stop <= FAST_STOP_RST;
        end else if (state_r == ST_RESET) begin
            fast_osc_stop <= FAST_STOP_RST;
        end else if (osc_wr && state_r == ST_RUN) begin
            fast_osc_stop <= i_wdata[OSC_STOP_BIT];
        end
    end

    // Status flags; earlier events in the table take precedence.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            time_out_flag_n   <= FLAG_RST;
            power_down_flag_n <= FLAG_RST;
        end else if (i_power_on_reset || i_low_voltage_reset) begin
            time_out_flag_n   <= 1'b1;
            power_down_flag_n <= 1'b1;
        end else if (i_watchdog_reset) begin
            time_out_flag_n   <= 1'b0;
            power_down_flag_n <= (state_r != ST_HALT);
        end else if (!pin_s2_r) begin
            if (state_r == ST_HALT || state_r == ST_WAKE) begin
                time_out_flag_n   <= 1'b1;
                power_down_flag_n <= 1'b1;
            end
        end else if (halt_req) begin
            time_out_flag_n   <= 1'b1;
            power_down_flag_n <= 1'b0;
        end else if (i_watchdog_clear_instruction && state_r == ST_RUN) begin
            time_out_flag_n   <= 1'b1;
            power_down_flag_n <= 1'b1;
        end
    end

    // Registered core and clock outputs.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_core_run        <= 1'b0;
            o_core_reset      <= 1'b1;
            o_sys_clk_fast    <= SEL_FAST_RST;
            o_fast_osc_en     <= 1'b1;
            o_slow_osc_en     <= 1'b1;
            o_periph_en       <= 1'b0;
            o_watchdog_clear  <= 1'b0;
        end else begin
            o_core_run     <= (state_r == ST_RUN) && !halt_req &&
                              !stby_req;
            o_core_reset   <= (state_r == ST_RESET) ||
                              (state_r == ST_PWRUP) || (state_r == ST_OST);
            o_sys_clk_fast <= sys_clk_select_fast;
            o_fast_osc_en  <= (state_r != ST_HALT) &&
                              !fast_osc_stop;
            o_slow_osc_en  <= (state_r != ST_HALT);
            o_periph_en    <= (state_r == ST_RUN);
            o_watchdog_clear  <= halt_req ||
                (i_watchdog_clear_instruction && state_r == ST_RUN);
        end
    end

    // Timer run enables and timer0 clock choice.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_timer_run       <= 3'h0;
            o_timer0_slow_clk <= 1'b0;
        end else begin
            if (state_r == ST_RUN || state_r == ST_STBY) begin
                o_timer_run <= {i_timer2_enable, i_timer1_enable,
                                i_timer0_enable};
            end else begin
                o_timer_run <= 3'h0;
            end
            o_timer0_slow_clk <= i_timer0_low_clock_sel &&
                                 i_timer0_src_opt;
        end
    end

    // Wake vector pulse when interrupts were on.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_wake_vector <= 1'b0;
        end else begin
            o_wake_vector <= i_global_int_en &&
                (((state_r == ST_STBY) && stby_wake_hit) ||
                 ((state_r == ST_WAKE) && wait_done));
        end
    end

    // Status flag outputs.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_time_out_flag_n   <= FLAG_RST;
            o_power_down_flag_n <= FLAG_RST;
        end else begin
            o_time_out_flag_n   <= time_out_flag_n;
            o_power_down_flag_n <= power_down_flag_n;
        end
    end

    // Read data, one cycle after the strobe.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            unique case (i_addr)
                ADDR_OSC: o_rdata <= {6'h00, fast_osc_stop,
                                      sys_clk_select_fast};
                ADDR_STS: o_rdata <= {6'h00, time_out_flag_n,
                                      power_down_flag_n};
                default:  o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end
endmodule : opmode_reset_ctrl
`default_nettype wire

// ---- bench/wake_src_model.sv ----
/*
 * Wake event source model: after a request it waits the asked number
 * of cycles, then pulses one wake line for one cycle.
 * Assumes one request at a time, one clock shared with the design.
 */
`timescale 1ns/1ps
`default_nettype none
module wake_src_model (
    // Clock and request
    input  wire logic       i_clk,
    input  wire logic       i_fire,
    input  wire logic [1:0] i_src,
    input  wire logic [9:0] i_delay,
    // Wake lines: timer, watchdog, port change, pin
    output logic [3:0]      o_wake
);
    int         left  = -1;
    logic [1:0] src_r = 2'h0;
    logic [3:0] wake_r = 4'h0;
    assign o_wake = wake_r;
    always @(posedge i_clk) begin
        wake_r <= 4'h0;
        if (i_fire) begin
            left  <= int'(i_delay);
            src_r <= i_src;
        end else if (left == 0) begin
            wake_r[src_r] <= 1'b1;
            left          <= -1;
        end else if (left > 0) begin
            left <= left - 1;
        end
    end
endmodule : wake_src_model
`default_nettype wire

// ---- bench/opmode_chk.sv ----
/*
 * Port checker for the operating-mode and reset sequencer.
 * Assumes it is bound to the sequencer and sees its ports only.
 */
`timescale 1ns/1ps
`default_nettype none
module opmode_chk (
    // Clock, reset and events
    input wire logic       i_clk, i_reset, i_power_on_reset,
    input wire logic       i_low_voltage_reset, i_watchdog_reset,
    input wire logic       i_ext_reset_pin_n, i_sleep_instruction,
    // Register port and options
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr, i_timer0_low_clock_sel, i_timer0_src_opt,
    // Outputs
    input wire logic       o_core_run, o_core_reset, o_sys_clk_fast,
    input wire logic       o_fast_osc_en, o_slow_osc_en, o_timer0_slow_clk,
    input wire logic       o_watchdog_clear, o_wake_vector,
    input wire logic [2:0] o_timer_run
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic wr0, halt_go;
    assign wr0 = i_wr && i_addr == 2'h0 && o_core_run;
    assign halt_go = (wr0 && i_wdata[3:2] == 2'h1)
                     || (i_sleep_instruction && o_core_run);
    a_halt_wdt_clear: assert property (halt_go |-> ##[1:2] o_watchdog_clear)
        else $error("watchdog clear missing on halt entry");
    a_halt_all_off: assert property (halt_go |-> ##3 (!o_core_run
        && !o_fast_osc_en && !o_slow_osc_en && o_timer_run == 3'h0))
        else $error("halt left a clock or timer running");
    a_stby_entry: assert property (wr0 && i_wdata[3:2] == 2'h2
        |-> ##3 (!o_core_run && o_slow_osc_en))
        else $error("standby entry wrong");
    a_slow_select: assert property (wr0 && i_wdata[3:0] == 4'h0
        |-> ##[1:2] !o_sys_clk_fast)
        else $error("slow select not taken");
    a_fast_kept: assert property (wr0 && i_wdata[3:0] == 4'h0
        |-> ##3 o_fast_osc_en)
        else $error("fast oscillator stopped without stop bit");
    a_reset_event: assert property ((i_power_on_reset || i_low_voltage_reset
        || i_watchdog_reset) |-> ##[1:2] (o_core_reset && !o_core_run))
        else $error("reset event not taken");
    a_pin_reset: assert property (!i_ext_reset_pin_n |-> ##[2:4] o_core_reset)
        else $error("pin reset not taken");
    a_reset_release: assert property ($fell(i_reset) |-> o_core_reset)
        else $error("core reset not held at release");
    a_normal_clocks: assert property (o_core_run && o_sys_clk_fast
        |-> o_fast_osc_en && o_slow_osc_en)
        else $error("normal mode clock missing");
    a_t0_slow_clk: assert property (o_core_run && o_sys_clk_fast
        && $past(i_timer0_low_clock_sel) && $past(i_timer0_src_opt)
        |-> o_timer0_slow_clk)
        else $error("timer0 slow clock not chosen");
    c_halt: cover property (halt_go);
    c_wake: cover property ($rose(o_core_run) && !o_core_reset);
    c_vector: cover property (o_wake_vector);
endmodule : opmode_chk
`default_nettype wire

// ---- bench/tb_top.sv ----
/*
 * Self-checking bench for the operating-mode and reset sequencer.
 * Assumes shortened power-up waits and a wake source model.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import opmode_pkg::*;
    logic i_clk = 0, i_reset = 1, i_wr = 0, i_rd = 0, gie = 0, fire = 0;
    logic fst = 1, t0low = 0, t0src = 0, rd_d = 0;
    logic [5:0] ev = 6'h0;
    logic [2:0] i_pwrup_sel = 3'h0, xt = 3'h0, ten = 3'h0;
    logic [1:0] i_addr = 2'h0, src = 2'h0;
    logic [7:0] i_wdata = 8'h00, exp_q[$];
    logic [9:0] dly = 10'h000;
    logic [31:0] rnd = 32'h0051;
    wire logic [7:0] o_rdata;
    wire logic [3:0] wk;
    wire logic [2:0] o_timer_run;
    wire logic o_core_run, o_core_reset, o_sys_clk_fast, o_fast_osc_en;
    wire logic o_slow_osc_en, o_timer0_slow_clk, o_watchdog_clear, o_wake_vector;
    wire logic o_periph_en, o_time_out_flag_n, o_power_down_flag_n;
    int miscompares = 0, checks_done = 0, vec_cnt = 0, wdc_cnt = 0, cyc = 0;
    opmode_reset_ctrl #(.P0_CYC(4), .P1_CYC(12), .P2_CYC(20), .P3_CYC(28),
        .P4_CYC(36)) u_opmode_reset_ctrl (.i_clk(i_clk), .i_reset(i_reset),
        .i_power_on_reset(ev[0]), .i_low_voltage_reset(ev[1]),
        .i_watchdog_reset(ev[2]), .i_ext_reset_pin_n(!ev[3]),
        .i_startup_fast(fst), .i_pwrup_sel(i_pwrup_sel),
        .i_high_crystal_mode(xt[0]), .i_mid_crystal_mode(xt[1]),
        .i_low_crystal_mode(xt[2]), .i_timer0_src_opt(t0src),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_sleep_instruction(ev[4]),
        .i_watchdog_clear_instruction(ev[5]), .i_global_int_en(gie),
        .i_timer0_enable(ten[0]), .i_timer1_enable(ten[1]),
        .i_timer2_enable(ten[2]), .i_timer0_low_clock_sel(t0low),
        .i_timer_wake(wk[0]), .i_watchdog_wake(wk[1]),
        .i_portb_change_wake(wk[2]), .i_ext_int_wake(wk[3]),
        .o_core_run(o_core_run), .o_core_reset(o_core_reset),
        .o_sys_clk_fast(o_sys_clk_fast), .o_fast_osc_en(o_fast_osc_en),
        .o_slow_osc_en(o_slow_osc_en), .o_periph_en(o_periph_en),
        .o_timer_run(o_timer_run), .o_timer0_slow_clk(o_timer0_slow_clk),
        .o_watchdog_clear(o_watchdog_clear), .o_wake_vector(o_wake_vector),
        .o_time_out_flag_n(o_time_out_flag_n),
        .o_power_down_flag_n(o_power_down_flag_n));
    wake_src_model u_wake_src_model (.i_clk(i_clk), .i_fire(fire),
        .i_src(src), .i_delay(dly), .o_wake(wk));
    initial forever #12.5 i_clk = ~i_clk;
    task automatic stop_test;
        if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    task automatic check(input logic [15:0] seen, exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
    endtask : step
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        i_addr <= a; i_wdata <= d; i_wr <= 1'b1; step(1); i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        exp_q.push_back(e); i_addr <= a; i_rd <= 1'b1; step(1);
        i_rd <= 1'b0; step(1);
    endtask : rd
    task automatic pulse(input int b, input int n);
        ev[b] <= 1'b1; step(n); ev[b] <= 1'b0; step(1);
    endtask : pulse
    task automatic wait_run(output int n);
        step(3); n = 3;
        while (o_core_run !== 1'b1 && n < 3000) begin step(1); n++; end
    endtask : wait_run
    task automatic rst_ev(input int b, input int w, input logic [7:0] f);
        int n;
        pulse(b, w); wait_run(n); rd(2'h1, f);
        check(16'({o_time_out_flag_n, o_power_down_flag_n}), 16'(f),
              "flag pins");
    endtask : rst_ev
    task automatic lp(input logic hlt, sel, input logic [1:0] s,
                      input logic how, ie, input logic [2:0] x, input int d);
        int n, v, w, e;
        wr(2'h0, {7'h0, sel}); rnd = xs(rnd);
        gie <= ie; xt <= x; ten <= rnd[2:0]; step(2);
        v = vec_cnt; w = wdc_cnt;
        if (hlt && !how) pulse(4, 1);
        else wr(2'h0, {4'h0, hlt ? 2'h1 : 2'h2, !sel, sel});
        step(3);
        if (hlt) begin
            check(16'({o_core_run, o_fast_osc_en, o_slow_osc_en, o_periph_en,
                  o_timer_run}), 16'h0, "halt outputs");
            check(16'(wdc_cnt - w), 16'h1, "wdt clear");
            fire <= 1'b1; src <= 2'h0; dly <= 10'h1; step(1); fire <= 1'b0;
            step(20); check(16'(o_core_run), 16'h0, "halt timer wake");
        end else check(16'({o_core_run, o_slow_osc_en, o_periph_en,
                       o_timer_run}), 16'({3'b010, rnd[2:0]}),
                       "standby outputs");
        fire <= 1'b1; src <= s; dly <= d[9:0]; step(1); fire <= 1'b0;
        wait_run(n); e = hlt ? (x != 3'h0 ? WAKE_XTAL_CYC : WAKE_RC_CYC) : 0;
        check(16'(n >= d + e && n <= d + e + 12), 16'h1, "wake time");
        check(16'(o_sys_clk_fast), 16'(sel), "wake clock");
        check(16'(o_fast_osc_en), 16'(!(how && !sel)), "fast stop");
        check(16'(vec_cnt - v), 16'(ie), "wake vector");
    endtask : lp
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13; s ^= s >> 17; s ^= s << 5;
        return s;
    endfunction : xs
    always @(posedge i_clk) begin
        rd_d <= i_rd; cyc++;
        if (o_wake_vector === 1'b1) vec_cnt++;
        if (o_watchdog_clear === 1'b1) wdc_cnt++;
        if (cyc == 20000) begin miscompares++; stop_test(); end
    end
    always @(negedge i_clk)
        if (rd_d) check(16'(o_rdata), 16'(exp_q.pop_front()), "rdata");
    initial begin
        int n, p;
        step(12); i_reset <= 1'b0; wait_run(n);
        check(16'(n >= 20 && n <= 32), 16'h1, "first start");
        for (int k = 0; k < 5; k++) begin
            i_pwrup_sel <= 3'(k); fst <= !k[0]; step(1);
            pulse(k % 2, 1); wait_run(n); p = 4 + 8 * k;
            check(16'(n >= p + 14 && n <= p + 22), 16'h1, "pwrup");
            step(2); check(16'(o_sys_clk_fast), 16'(!k[0]), "start");
            rd(2'h1, 8'h03);
        end
        wr(2'h0, 8'h00); step(3);
        check(16'({o_sys_clk_fast, o_fast_osc_en}), 16'h1, "slow");
        wr(2'h0, 8'h02); step(3);
        check(16'(o_fast_osc_en), 16'h0, "fast stop bit");
        wr(2'h0, 8'h01); t0low <= 1'b1; t0src <= 1'b1; step(3);
        check(16'({o_sys_clk_fast, o_timer0_slow_clk}), 16'h3, "t0");
        t0low <= 1'b0;
        lp(0, 1, 2'h0, 1, 0, 3'h0, 3); lp(0, 0, 2'h1, 1, 1, 3'h0, 40);
        lp(0, 1, 2'h2, 1, 1, 3'h0, 0); lp(0, 0, 2'h3, 1, 0, 3'h0, 7);
        lp(1, 1, 2'h1, 0, 1, 3'h1, 5); rd(2'h1, 8'h02);
        pulse(5, 1); rd(2'h1, 8'h03);
        lp(1, 0, 2'h2, 1, 0, 3'h0, 0); lp(1, 1, 2'h3, 0, 0, 3'h4, 9);
        lp(1, 1, 2'h2, 1, 1, 3'h2, 2);
        rst_ev(2, 1, 8'h01); rst_ev(3, 2, 8'h01);
        pulse(4, 1); step(4); rst_ev(2, 1, 8'h00);
        pulse(4, 1); step(4); rst_ev(3, 2, 8'h03);
        rnd = xs(rnd); wr(2'h2 + 2'(rnd[0]), rnd[15:8]);
        rd(2'h2, 8'h00); rd(2'h3, 8'h00);
        i_reset <= 1'b1; step(3); i_reset <= 1'b0; wait_run(n);
        check(16'(o_core_run), 16'h1, "second reset");
        stop_test();
    end
endmodule : tb_top
bind opmode_reset_ctrl opmode_chk u_opmode_chk (.i_clk(i_clk),
    .i_reset(i_reset), .i_power_on_reset(i_power_on_reset),
    .i_low_voltage_reset(i_low_voltage_reset),
    .i_watchdog_reset(i_watchdog_reset), .i_ext_reset_pin_n(i_ext_reset_pin_n),
    .i_sleep_instruction(i_sleep_instruction), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr),
    .i_timer0_low_clock_sel(i_timer0_low_clock_sel),
    .i_timer0_src_opt(i_timer0_src_opt), .o_core_run(o_core_run),
    .o_core_reset(o_core_reset), .o_sys_clk_fast(o_sys_clk_fast),
    .o_fast_osc_en(o_fast_osc_en), .o_slow_osc_en(o_slow_osc_en),
    .o_timer0_slow_clk(o_timer0_slow_clk), .o_watchdog_clear(o_watchdog_clear),
    .o_wake_vector(o_wake_vector), .o_timer_run(o_timer_run));
`default_nettype wire
